//--- core/tfs_pkg.sv
// Package: constants for the transmit frame-size statistics counters
package tfs_pkg;
    // Number of length bins kept here
    localparam int unsigned NUM_CNT = 3;
    // Counter and bus data width
    localparam int unsigned CNT_W = 32;
    // Memory-space window is 512 bytes, so 9 address bits
    localparam int unsigned ADDR_W = 9;
    // Frame length input width in octets
    localparam int unsigned LEN_W = 16;

    // Byte offsets of the counters inside the memory window
    localparam logic [8:0] OFF_CNT_256_511 = 9'h118;
    localparam logic [8:0] OFF_CNT_512_1023 = 9'h11C;
    localparam logic [8:0] OFF_CNT_1024_1518 = 9'h120;

    // Reset value of every counter
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    // Count value that raises the statistics-update flag
    localparam logic [31:0] CNT_UPDATE_MARK = 32'h0000_C000;
    // Read data for an unmapped offset
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Length of a VLAN tag in octets
    localparam logic [15:0] VLAN_TAG_LEN = 16'h0004;
    // Bin bounds in octets, inclusive
    localparam logic [15:0] BIN0_LO = 16'h0100;
    localparam logic [15:0] BIN0_HI = 16'h01FF;
    localparam logic [15:0] BIN1_LO = 16'h0200;
    localparam logic [15:0] BIN1_HI = 16'h03FF;
    localparam logic [15:0] BIN2_LO = 16'h0400;
    localparam logic [15:0] BIN2_HI = 16'h05EE;

    // Bit of each counter in the mask input
    localparam int unsigned MASK_BIT_256_511 = 0;
    localparam int unsigned MASK_BIT_512_1023 = 1;
    localparam int unsigned MASK_BIT_1024_1518 = 2;
endpackage

//--- core/tfs_counter.sv
// One 32-bit statistics counter with host load and mark detection
module tfs_counter (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic inc_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] count_o,
    output logic mark_o
);
    // Counter state and its next value
    logic [31:0] count_reg;
    logic [31:0] count_next;
    // Incremented value; wraps to zero after all ones
    logic [31:0] count_plus;

    assign count_plus = count_reg + 32'h0000_0001;
    // Host write wins over a same-cycle frame so software sees its value
    assign count_next = wr_i ? wdata_i : (inc_i ? count_plus : count_reg);
    // Mark fires only on the increment that lands on the mark value
    assign mark_o = inc_i && !wr_i && (count_plus == tfs_pkg::CNT_UPDATE_MARK);
    assign count_o = count_reg;

    // Counter register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            count_reg <= tfs_pkg::CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // Wrap check: all ones steps to zero
    chk_counter_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (inc_i && !wr_i && count_reg == 32'hFFFF_FFFF) |=> count_reg == 32'h0000_0000)
        else $error("counter did not wrap to zero");
endmodule

//--- core/tfs_tx_size_stats.sv
// Top: transmit frame-size bin counters behind the memory-space window
// How it works
// - Count transmitted frames per three length bins
// - Classified length always includes the VLAN tag
// - Reaching 0xC000 raises the statistics-update flag
// - Count only if enabled and not masked
// - Counters decode in memory space only
module tfs_tx_size_stats (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Transmit side: one pulse per completed frame
    input wire logic tx_frame_done_i,
    // Frame length in octets as handed to the MAC
    input wire logic [15:0] tx_frame_len_i,
    // High when the MAC inserts a tag not counted in tx_frame_len_i
    input wire logic tx_vlan_inserted_i,
    // Global statistics enable from the MAC control register
    input wire logic global_stats_enable_i,
    // Per-counter mask bits from the RMON counter mask register
    input wire logic [2:0] rmon_counter_mask_i,
    // Host slave access
    input wire logic mem_cs_i,
    input wire logic io_cs_i,
    input wire logic [8:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rd_valid_o,
    // One-cycle set pulse for the interrupt status register
    output logic stats_update_flag_o
);
    // Length with the tag always counted
    logic [15:0] eff_len;
    // One-hot bin match
    logic [2:0] bin_hit;
    // Per-counter increment, write and mark
    logic [2:0] cnt_inc;
    logic [2:0] cnt_wr;
    logic [2:0] cnt_mark;
    // Per-counter offset match in memory space
    logic [2:0] cnt_sel;
    // Counter values
    logic [31:0] cnt_val [3];
    // Offsets in counter index order
    logic [8:0] cnt_off [3];
    // Any offset matched
    logic any_sel;
    // Selected read data
    logic [31:0] rd_mux;
    // Registered outputs
    logic [31:0] rdata_reg;
    logic rd_valid_reg;
    logic flag_reg;
    // Access is a memory-space double-word access
    logic mem_dw;

    // Frame length: an inserted tag is added so both cases count alike
    // The sum wraps only for lengths within four of 0xFFFF, which fit no bin anyway
    assign eff_len = tx_vlan_inserted_i ? (tx_frame_len_i + tfs_pkg::VLAN_TAG_LEN)
                                        : tx_frame_len_i;

    // Bin decode on the tagged length
    assign bin_hit[0] = (eff_len >= tfs_pkg::BIN0_LO) && (eff_len <= tfs_pkg::BIN0_HI);
    assign bin_hit[1] = (eff_len >= tfs_pkg::BIN1_LO) && (eff_len <= tfs_pkg::BIN1_HI);
    assign bin_hit[2] = (eff_len >= tfs_pkg::BIN2_LO) && (eff_len <= tfs_pkg::BIN2_HI);

    // Offset table indexed like the counters, so the decode can loop
    assign cnt_off[0] = tfs_pkg::OFF_CNT_256_511;
    assign cnt_off[1] = tfs_pkg::OFF_CNT_512_1023;
    assign cnt_off[2] = tfs_pkg::OFF_CNT_1024_1518;

    // I/O-space cycles never reach the counters; only memory cycles decode
    assign mem_dw = mem_cs_i && (addr_i[1:0] == 2'h0);

    // Per-counter control and counter instances
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
            // Enable and mask gate each increment
            assign cnt_inc[gi] = tx_frame_done_i && bin_hit[gi] && global_stats_enable_i
                                 && !rmon_counter_mask_i[gi];
            assign cnt_sel[gi] = mem_dw && (addr_i == cnt_off[gi]);
            assign cnt_wr[gi] = cnt_sel[gi] && wr_en_i;
            // One counter per bin, so a host load touches only its own word
            tfs_counter u_cnt (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .inc_i(cnt_inc[gi]),
                .wr_i(cnt_wr[gi]),
                .wdata_i(wdata_i),
                .count_o(cnt_val[gi]),
                .mark_o(cnt_mark[gi])
            );
        end
    endgenerate

    // Read selection; unmapped memory offsets read as zero
    assign any_sel = |cnt_sel;
    assign rd_mux = cnt_sel[0] ? cnt_val[0] :
                    cnt_sel[1] ? cnt_val[1] :
                    cnt_sel[2] ? cnt_val[2] : tfs_pkg::RD_UNMAPPED;

    // Read answer one cycle after the request, memory space only
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= tfs_pkg::RD_UNMAPPED;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= mem_cs_i && rd_en_i;
            rdata_reg <= (mem_cs_i && rd_en_i && any_sel) ? rd_mux : tfs_pkg::RD_UNMAPPED;
        end
    end

    // Update flag: a registered pulse per mark; the status bit lives elsewhere
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= |cnt_mark;
        end
    end

    // Outputs come straight from the registers above
    assign rdata_o = rdata_reg;
    assign rd_valid_o = rd_valid_reg;
    assign stats_update_flag_o = flag_reg;

    // Checks on the counters and the slave
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // A 512-octet untagged frame steps the middle bin by one
    chk_bin_count_step: assert property (
        (tx_frame_done_i && !tx_vlan_inserted_i && tx_frame_len_i == 16'h0200
         && global_stats_enable_i && !rmon_counter_mask_i[1] && !cnt_wr[1])
        |=> cnt_val[1] == $past(cnt_val[1]) + 32'h0000_0001)
        else $error("512 octet frame not counted in middle bin");

    // An inserted tag lifts a 508-octet frame into the middle bin
    chk_vlan_tag_len: assert property (
        (tx_frame_done_i && tx_vlan_inserted_i && tx_frame_len_i == 16'h01FC
         && global_stats_enable_i && !rmon_counter_mask_i[1] && !cnt_wr[1])
        |=> cnt_val[1] == $past(cnt_val[1]) + 32'h0000_0001)
        else $error("inserted tag not counted in frame length");

    // The flag pulse only appears while some counter sits at the mark
    chk_update_flag_mark: assert property (
        stats_update_flag_o |-> (cnt_val[0] == 32'h0000_C000 || cnt_val[1] == 32'h0000_C000
                                 || cnt_val[2] == 32'h0000_C000))
        else $error("update flag without a counter at the mark");

    // Judged from the counters themselves, not from the mark wires
    chk_flag_follows_mark: assert property (
        ((cnt_inc[0] && !cnt_wr[0] && cnt_val[0] == 32'h0000_BFFF)
         || (cnt_inc[1] && !cnt_wr[1] && cnt_val[1] == 32'h0000_BFFF)
         || (cnt_inc[2] && !cnt_wr[2] && cnt_val[2] == 32'h0000_BFFF))
        |=> stats_update_flag_o)
        else $error("mark reached but update flag not raised");

    // With statistics off only a host write may move a counter
    chk_enable_gates_count: assert property (
        (!global_stats_enable_i && !(wr_en_i && mem_cs_i)) |=> $stable(cnt_val[0])
        && $stable(cnt_val[1]) && $stable(cnt_val[2]))
        else $error("counter moved while statistics disabled");

    // A set mask bit freezes the top-bin counter
    chk_mask_gates_count: assert property (
        (rmon_counter_mask_i[2] && !cnt_wr[2]) |=> $stable(cnt_val[2]))
        else $error("masked counter moved");

    // I/O-space cycles never get an answer
    chk_io_space_ignored: assert property (
        (io_cs_i && !mem_cs_i) |=> !rd_valid_o)
        else $error("I/O space access answered");

    // A host write to the low-bin counter loads the written word on the next edge
    chk_host_write_load: assert property (
        cnt_wr[0] |=> cnt_val[0] == $past(wdata_i))
        else $error("host write not loaded into counter");

    // A frame one octet past the top bin lands nowhere
    chk_bin_top_edge: assert property (
        (tx_frame_done_i && !tx_vlan_inserted_i && tx_frame_len_i == 16'h05EF
         && !(mem_cs_i && wr_en_i))
        |=> $stable(cnt_val[0]) && $stable(cnt_val[1]) && $stable(cnt_val[2]))
        else $error("frame above the top bin was counted");

    // The tag can push a frame out of the top bin as well as into one
    chk_vlan_past_top: assert property (
        (tx_frame_done_i && tx_vlan_inserted_i && tx_frame_len_i == 16'h05EB
         && !(mem_cs_i && wr_en_i))
        |=> $stable(cnt_val[0]) && $stable(cnt_val[1]) && $stable(cnt_val[2]))
        else $error("tagged frame above the top bin was counted");

    // Mask on the low bin holds that counter while the others may run
    chk_mask_low_bin: assert property (
        (rmon_counter_mask_i[0] && !cnt_wr[0]) |=> $stable(cnt_val[0]))
        else $error("masked low-bin counter moved");

    // An I/O-space write must leave every counter where it was
    chk_io_write_ignored: assert property (
        (io_cs_i && !mem_cs_i && wr_en_i && !tx_frame_done_i)
        |=> $stable(cnt_val[0]) && $stable(cnt_val[1]) && $stable(cnt_val[2]))
        else $error("I/O space write reached a counter");

    // Every memory read gets its answer on the next edge
    chk_read_answered: assert property (
        (mem_cs_i && rd_en_i) |=> rd_valid_o)
        else $error("memory read not answered");

    // Read data is the counter as it stood when the read was taken
    chk_read_low_bin: assert property (
        (mem_cs_i && rd_en_i && addr_i == tfs_pkg::OFF_CNT_256_511)
        |=> rdata_o == $past(cnt_val[0]))
        else $error("read data differs from the low-bin counter");

    // Outside an answer the read data rests at zero
    chk_read_idle_zero: assert property (
        !rd_valid_o |-> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside an answer");

    // Main scenarios reached by the bench
    cov_vlan_tagged: cover property (tx_frame_done_i && tx_vlan_inserted_i && cnt_inc[1]);
    cov_bin_small: cover property (cnt_inc[0]);
    cov_bin_large: cover property (cnt_inc[2] ##1 cnt_inc[2]);
    cov_update_flag: cover property (stats_update_flag_o);
    cov_read_back: cover property (rd_valid_o && rdata_o != 32'h0000_0000);
endmodule

//--- bench/tfs_tx_size_stats_tb_top.sv
// Self-checking bench for the transmit frame-size statistics counters
module tfs_tx_size_stats_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic tx_frame_done_i = 1'b0;
    logic [15:0] tx_frame_len_i = 16'h0000;
    logic tx_vlan_inserted_i = 1'b0;
    logic global_stats_enable_i = 1'b0;
    logic [2:0] rmon_counter_mask_i = 3'h0;
    logic mem_cs_i = 1'b0;
    logic io_cs_i = 1'b0;
    logic [8:0] addr_i = 9'h000;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic [31:0] rdata_o;
    logic rd_valid_o;
    logic stats_update_flag_o;
    int n_fail = 0; // Mismatches seen
    int comparisons = 0; // Compares made
    int seed = 92837; // Fixed seed keeps runs repeatable
    logic [31:0] exp_cnt [3]; // Bench copy of the three counters
    logic [31:0] rdv; // Last read answer
    logic [31:0] rdd;
    logic [8:0] offs [3] = '{9'h118, 9'h11C, 9'h120}; // Counter byte offsets
    // Bin edges; the last three are sent with a tag inserted
    logic [15:0] corner [11] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h03FF,
                                 16'h0400, 16'h05EE, 16'h05EF, 16'h00FC, 16'h05EB, 16'h01FC};
    tfs_tx_size_stats dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .tx_frame_done_i(tx_frame_done_i), .tx_frame_len_i(tx_frame_len_i),
        .tx_vlan_inserted_i(tx_vlan_inserted_i), .global_stats_enable_i(global_stats_enable_i),
        .rmon_counter_mask_i(rmon_counter_mask_i), .mem_cs_i(mem_cs_i), .io_cs_i(io_cs_i),
        .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .stats_update_flag_o(stats_update_flag_o));
    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    // Bin index from length plus tag octets, 3 when no bin applies
    function automatic int bin_of(input logic [15:0] len, input logic vl);
        logic [16:0] e;
        e = {1'b0, len} + (vl ? 17'h0_0004 : 17'h0_0000);
        if (e >= 17'h0_0100 && e <= 17'h0_01FF) return 0;
        if (e >= 17'h0_0200 && e <= 17'h0_03FF) return 1;
        if (e >= 17'h0_0400 && e <= 17'h0_05EE) return 2;
        return 3;
    endfunction
    // Compare and tally
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single verdict point for normal end and for the watchdog
    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One host cycle then one idle cycle; idle cycle checks the answer drops
    task automatic host(input logic mem, input logic io, input logic wr, input logic [8:0] a,
                        input logic [31:0] d);
        tx_frame_done_i = 1'b0;
        mem_cs_i = mem;
        io_cs_i = io;
        wr_en_i = wr;
        rd_en_i = !wr;
        addr_i = a;
        wdata_i = d;
        @(posedge mclk_i);
        #1;
        rdv = {31'h0, rd_valid_o};
        rdd = rdata_o;
        mem_cs_i = 1'b0;
        io_cs_i = 1'b0;
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        @(posedge mclk_i);
        #1;
        check({31'h0, rd_valid_o}, 32'h0);
    endtask
    // Memory-space read with expected data
    task automatic rd(input logic [8:0] a, input logic [31:0] exp);
        host(1'b1, 1'b0, 1'b0, a, 32'h0);
        check(rdv, 32'h1);
        check(rdd, exp);
    endtask
    // One frame; strobe left high so frames can run back to back
    task automatic frame(input logic [15:0] len, input logic vl, input logic en,
                         input logic [2:0] msk);
        int b;
        logic hit;
        b = bin_of(len, vl);
        hit = 1'b0;
        tx_frame_done_i = 1'b1;
        tx_frame_len_i = len;
        tx_vlan_inserted_i = vl;
        global_stats_enable_i = en;
        rmon_counter_mask_i = msk;
        @(posedge mclk_i);
        #1;
        if (b < 3) begin
            if (en && !msk[b]) begin
                exp_cnt[b] = exp_cnt[b] + 32'h1;
                hit = (exp_cnt[b] == 32'h0000_C000);
            end
        end
        check({31'h0, stats_update_flag_o}, {31'h0, hit});
    endtask
    // Watchdog well beyond the expected run of under 500 cycles
    initial begin
        #200us;
        n_fail++;
        give_verdict();
    end
    initial begin
        int r;
        for (int i = 0; i < 3; i++) exp_cnt[i] = 32'h0;
        repeat (4) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        for (int i = 0; i < 3; i++) rd(offs[i], 32'h0);
        $display("test reset values done");
        // Bin edges, tag added at the edges, then a middle-bin frame with only one mask bit clear in turn, then enable off
        for (int i = 0; i < 11; i++) frame(corner[i], i >= 8, 1'b1, 3'h0);
        for (int i = 0; i < 3; i++) frame(16'h02BC, 1'b0, 1'b1, 3'h7 ^ (3'h1 << i));
        for (int i = 0; i < 3; i++) frame(corner[2 * i + 1], 1'b0, 1'b0, 3'h0);
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            frame(16'(32'h0000_00C8 + ($unsigned(r) % 32'h0000_0578)), r[20],
                  r[1:0] != 2'h0, r[4:2] & r[7:5]);
        end
        for (int i = 0; i < 3; i++) rd(offs[i], exp_cnt[i]);
        $display("test binning and gating done");
        // I/O space, unaligned and unmapped accesses
        host(1'b0, 1'b1, 1'b1, offs[0], 32'h1234_5678);
        host(1'b0, 1'b1, 1'b0, offs[0], 32'h0);
        check(rdv, 32'h0);
        host(1'b1, 1'b0, 1'b1, 9'h119, 32'h1234_5678);
        rd(offs[0], exp_cnt[0]);
        rd(9'h124, 32'h0);
        rd(9'h119, 32'h0);
        $display("test refused accesses done");
        // Load below the mark, cross it, then wrap from all ones
        for (int i = 0; i < 3; i++) begin
            host(1'b1, 1'b0, 1'b1, offs[i], 32'h0000_BFFF);
            exp_cnt[i] = 32'h0000_BFFF;
            frame(corner[2 * i + 1], 1'b0, 1'b1, 3'h0);
            rd(offs[i], 32'h0000_C000);
            host(1'b1, 1'b0, 1'b1, offs[i], 32'hFFFF_FFFF);
            exp_cnt[i] = 32'hFFFF_FFFF;
            frame(corner[2 * i + 1], 1'b0, 1'b1, 3'h0);
            rd(offs[i], 32'h0);
        end
        $display("test mark and wrap done");
        give_verdict();
    end
endmodule
